// >>> ass_defs.vh
// Notes on behaviour
// - Pulse run at capture start, latch at end.
// - Misc capture length is 10-bit split field.
// - Left/right capture share one 10-bit length.
// - Valid flag set at capture end, self-clears.
// - Misc result 15 bits, split over two registers.
// - Period is sum of enabled state lengths.
// - Set length is shared 4-bit field.
// - Converter powered down from reset until cleared.
// - Right channel needs left channel enabled.
`ifndef ASS_DEFS_VH
`define ASS_DEFS_VH
// ==========================================
// Register byte offsets
`define ASS_OFF_INSEL_MISC 8'h00
`define ASS_OFF_INSEL_LEFT 8'h04
`define ASS_OFF_INSEL_RIGHT 8'h08
`define ASS_OFF_MISC_CAP_LO 8'h0c
`define ASS_OFF_LR_CAP_LO 8'h10
`define ASS_OFF_LEN_HI 8'h14
`define ASS_OFF_CHAN_CTRL 8'h18
`define ASS_OFF_MISC_DAT_LO 8'h1c
`define ASS_OFF_MISC_DAT_HI 8'h20
`define ASS_OFF_POWER 8'h24
`define ASS_OFF_IRQ_STAT 8'h28
`define ASS_OFF_IRQ_MASK 8'h2c
`define ASS_OFF_LEFT_DAT 8'h30
`define ASS_OFF_RIGHT_DAT 8'h34
// ==========================================
// Field positions
`define ASS_LEN_SET_LSB 0
`define ASS_LEN_LR_LSB 4
`define ASS_LEN_MISC_LSB 6
`define ASS_EN_LEFT_BIT 0
`define ASS_EN_RIGHT_BIT 1
`define ASS_EN_MISC_BIT 2
`define ASS_MAXIDX_LSB 4
`define ASS_PD_BIT 5
`define ASS_VALID_BIT 7
// ==========================================
// Reset values
`define ASS_RST_POWER 8'h20
`define ASS_RST_CTRL 8'h00
`define ASS_RST_BYTE 8'h00
// ==========================================
// Event bits of interrupt status
`define ASS_IRQ_LEFT 0
`define ASS_IRQ_RIGHT 1
`define ASS_IRQ_MISC 2
`endif

// >>> ass_state_timer.v
`timescale 1ns/100ps
// ==========================================
// Up counter timing one Set or Capture state
module ass_state_timer
(
	input wire clk_i,
	input wire rst_i,
	input wire load_i,
	input wire [9:0] length_i,
	input wire run_i,
	output wire last_o
);
	reg [9:0] cnt_q;
	reg [9:0] cnt_d;

	// Counts cycles spent in the state; a load restarts it for the next state
	always @*
	begin
		cnt_d = cnt_q;
		if (load_i)
			cnt_d = 10'h000;
		else if (run_i && !last_o)
			cnt_d = cnt_q + 10'h001;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			cnt_q <= 10'h000;
		else
			cnt_q <= cnt_d;
	end

	// Live length compare, so the length always belongs to the running state
	// A length of zero or one both give a one-cycle state, no state is shorter
	assign last_o = run_i && (({1'b0, cnt_q} + 11'h001) >= {1'b0, length_i});
endmodule

// >>> ass_chan_order.v
`timescale 1ns/100ps
// ==========================================
// Maps a state index to the channel it serves
module ass_chan_order
(
	input wire [2:0] index_i,
	input wire en_left_i,
	input wire en_right_i,
	input wire en_misc_i,
	output reg [1:0] chan_o,
	output wire capture_o
);
	// Fixed order left, right, misc; skipped channels close the gap
	reg [1:0] slot;
	always @*
	begin
		slot = index_i[2:1];
		chan_o = 2'h3;
		if (en_left_i)
		begin
			if (slot == 2'h0)
				chan_o = 2'h0;
			slot = slot - 2'h1;
		end
		if (en_right_i && chan_o == 2'h3)
		begin
			if (slot == 2'h0)
				chan_o = 2'h1;
			slot = slot - 2'h1;
		end
		if (en_misc_i && chan_o == 2'h3 && slot == 2'h0)
			chan_o = 2'h2;
	end

	assign capture_o = index_i[0];
endmodule

// >>> ass_sequencer.v
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "ass_defs.vh"
// ==========================================
// Auto-mode sampling sequencer with Wishbone register file
module ass_sequencer
(
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	output wire irq_o,
	input wire [14:0] conv_data_i,
	output reg conv_run_o,
	output reg [1:0] conv_chan_o,
	output reg [7:0] conv_insel_o,
	output reg conv_set_o,
	output wire converter_powerdown_o,
	output reg sample_valid_flag_o,
	output reg [14:0] left_data_o,
	output reg [14:0] right_data_o
);
	// ==========================================
	// Register storage
	reg [7:0] insel_misc_q;
	reg [7:0] insel_left_q;
	reg [7:0] insel_right_q;
	reg [7:0] misc_cap_lo_q;
	reg [7:0] lr_cap_lo_q;
	reg [7:0] len_hi_q;
	reg [7:0] chan_ctrl_q;
	reg [7:0] power_q;
	reg [14:0] misc_data_q;
	reg [2:0] irq_stat_q;
	reg [2:0] irq_mask_q;
	reg ack_q;
	reg [2:0] index_q;
	reg active_q;

	wire wr_en;
	wire rd_en;
	wire [9:0] misc_capture_length;
	wire [9:0] lr_capture_length;
	wire [9:0] set_length;
	wire en_left;
	wire en_right;
	wire en_misc;
	wire [2:0] max_index;
	wire can_run;
	wire [1:0] chan;
	wire capture;
	wire state_last;
	wire [9:0] state_len;
	wire [2:0] next_index;
	wire start_state;
	wire [2:0] nxt_state_index;
	wire [1:0] nxt_chan;
	wire nxt_capture;
	wire pd_write;
	wire pd_next;
	wire run_next;
	reg [2:0] irq_set;

	// Byte-lane write with lane 0 only, wider lanes hold nothing
	function [7:0] lane_wr;
		input [7:0] old;
		input [31:0] data;
		input [3:0] sel;
		begin
			lane_wr = sel[0] ? data[7:0] : old;
		end
	endfunction

	// Zero-extend a byte to the bus width
	function [31:0] ext8;
		input [7:0] v;
		begin
			ext8 = {24'h000000, v};
		end
	endfunction

	// Input select byte of one channel; upper nibble positive, lower negative
	function [7:0] insel_for;
		input [1:0] ch;
		input [7:0] left;
		input [7:0] right;
		input [7:0] misc;
		begin
			case (ch)
				2'h0: insel_for = left;
				2'h1: insel_for = right;
				default: insel_for = misc;
			endcase
		end
	endfunction

	// ==========================================
	// Bus slave: one wait state, ack falls the cycle after it rose
	assign wr_en = cyc_i && stb_i && we_i && !ack_q;
	assign rd_en = cyc_i && stb_i && !we_i && !ack_q;
	assign ack_o = ack_q;

	always @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= cyc_i && stb_i && !ack_q;
	end

	// ==========================================
	// Field decode
	assign misc_capture_length = {len_hi_q[`ASS_LEN_MISC_LSB+1:`ASS_LEN_MISC_LSB], misc_cap_lo_q};
	assign lr_capture_length = {len_hi_q[`ASS_LEN_LR_LSB+1:`ASS_LEN_LR_LSB], lr_cap_lo_q};
	assign set_length = {6'h00, len_hi_q[`ASS_LEN_SET_LSB+3:`ASS_LEN_SET_LSB]};
	assign en_left = chan_ctrl_q[`ASS_EN_LEFT_BIT];
	assign en_right = chan_ctrl_q[`ASS_EN_RIGHT_BIT] && en_left;
	assign en_misc = chan_ctrl_q[`ASS_EN_MISC_BIT];
	assign max_index = chan_ctrl_q[`ASS_MAXIDX_LSB+2:`ASS_MAXIDX_LSB];
	assign converter_powerdown_o = power_q[`ASS_PD_BIT];
	// Idle unless powered, left or misc is on, and max_index is nonzero
	assign can_run = !converter_powerdown_o && (en_left || en_misc) && max_index != 3'h0;

	// ==========================================
	// Register writes; the powerdown bit resets high
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			insel_misc_q <= `ASS_RST_BYTE;
			insel_left_q <= `ASS_RST_BYTE;
			insel_right_q <= `ASS_RST_BYTE;
			misc_cap_lo_q <= `ASS_RST_BYTE;
			lr_cap_lo_q <= `ASS_RST_BYTE;
			len_hi_q <= `ASS_RST_BYTE;
			chan_ctrl_q <= `ASS_RST_CTRL;
			power_q <= `ASS_RST_POWER;
			irq_mask_q <= 3'h0;
		end
		else if (wr_en)
		begin
			case (adr_i)
				`ASS_OFF_INSEL_MISC: insel_misc_q <= lane_wr(insel_misc_q, dat_i, sel_i);
				`ASS_OFF_INSEL_LEFT: insel_left_q <= lane_wr(insel_left_q, dat_i, sel_i);
				`ASS_OFF_INSEL_RIGHT: insel_right_q <= lane_wr(insel_right_q, dat_i, sel_i);
				`ASS_OFF_MISC_CAP_LO: misc_cap_lo_q <= lane_wr(misc_cap_lo_q, dat_i, sel_i);
				`ASS_OFF_LR_CAP_LO: lr_cap_lo_q <= lane_wr(lr_cap_lo_q, dat_i, sel_i);
				`ASS_OFF_LEN_HI: len_hi_q <= lane_wr(len_hi_q, dat_i, sel_i);
				`ASS_OFF_CHAN_CTRL: chan_ctrl_q <= lane_wr(chan_ctrl_q, dat_i, sel_i);
				`ASS_OFF_POWER: power_q <= lane_wr(power_q, dat_i, sel_i);
				`ASS_OFF_IRQ_MASK: irq_mask_q <= sel_i[0] ? dat_i[2:0] : irq_mask_q;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Read mux; unmapped offsets read zero and still ack
	always @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h00000000;
		else if (rd_en)
		begin
			case (adr_i)
				`ASS_OFF_INSEL_MISC: dat_o <= ext8(insel_misc_q);
				`ASS_OFF_INSEL_LEFT: dat_o <= ext8(insel_left_q);
				`ASS_OFF_INSEL_RIGHT: dat_o <= ext8(insel_right_q);
				`ASS_OFF_MISC_CAP_LO: dat_o <= ext8(misc_cap_lo_q);
				`ASS_OFF_LR_CAP_LO: dat_o <= ext8(lr_cap_lo_q);
				`ASS_OFF_LEN_HI: dat_o <= ext8(len_hi_q);
				`ASS_OFF_CHAN_CTRL: dat_o <= ext8(chan_ctrl_q);
				`ASS_OFF_POWER: dat_o <= ext8(power_q);
				`ASS_OFF_MISC_DAT_LO: dat_o <= ext8(misc_data_q[7:0]);
				`ASS_OFF_MISC_DAT_HI: dat_o <= ext8({sample_valid_flag_o, misc_data_q[14:8]});
				`ASS_OFF_IRQ_STAT: dat_o <= {29'h00000000, irq_stat_q};
				`ASS_OFF_IRQ_MASK: dat_o <= {29'h00000000, irq_mask_q};
				`ASS_OFF_LEFT_DAT: dat_o <= {17'h00000, left_data_o};
				`ASS_OFF_RIGHT_DAT: dat_o <= {17'h00000, right_data_o};
				default: dat_o <= 32'h00000000;
			endcase
		end
	end

	// ==========================================
	// State walk
	ass_chan_order u_order
	(
		.index_i(index_q),
		.en_left_i(en_left),
		.en_right_i(en_right),
		.en_misc_i(en_misc),
		.chan_o(chan),
		.capture_o(capture)
	);

	// Capture length follows the channel, set length is shared
	assign state_len = !capture ? set_length : (chan == 2'h2) ? misc_capture_length : lr_capture_length;
	// Wrap after index max_index minus one, so max_index counts the states
	assign next_index = (index_q >= max_index - 3'h1) ? 3'h0 : index_q + 3'h1;
	assign start_state = can_run && (!active_q || state_last);

	// ==========================================
	// Lookahead of the coming cycle's state
	// The converter strobes are registered; deriving them from the coming
	// state keeps them aligned with the state instead of a cycle behind
	assign nxt_state_index = !active_q ? 3'h0 : state_last ? next_index : index_q;

	ass_chan_order u_order_nxt
	(
		.index_i(nxt_state_index),
		.en_left_i(en_left),
		.en_right_i(en_right),
		.en_misc_i(en_misc),
		.chan_o(nxt_chan),
		.capture_o(nxt_capture)
	);

	// A power-down write landing this edge already blocks new strobes
	assign pd_write = wr_en && (adr_i == `ASS_OFF_POWER) && sel_i[0];
	assign pd_next = pd_write ? dat_i[`ASS_PD_BIT] : converter_powerdown_o;
	assign run_next = can_run && !pd_next;

	ass_state_timer u_timer
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(start_state),
		.length_i(state_len),
		.run_i(active_q),
		.last_o(state_last)
	);

	// Index advances at each state end, and restarts from zero when idle
	always @(posedge clk_i)
	begin
		if (rst_i || !can_run)
		begin
			index_q <= 3'h0;
			active_q <= 1'b0;
		end
		else
		begin
			active_q <= 1'b1;
			if (active_q && state_last)
				index_q <= next_index;
		end
	end

	// ==========================================
	// Converter strobes, capture and valid flag
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			conv_run_o <= 1'b0;
			conv_set_o <= 1'b0;
			conv_chan_o <= 2'h0;
			conv_insel_o <= 8'h00;
			sample_valid_flag_o <= 1'b0;
			misc_data_q <= 15'h0000;
			left_data_o <= 15'h0000;
			right_data_o <= 15'h0000;
		end
		else
		begin
			conv_run_o <= 1'b0;
			sample_valid_flag_o <= 1'b0; // Self-clears the next cycle
			conv_set_o <= run_next && !nxt_capture && nxt_chan != 2'h3;
			conv_chan_o <= run_next ? nxt_chan : 2'h3;
			// Upper nibble positive, lower nibble negative select
			conv_insel_o <= insel_for(nxt_chan, insel_left_q, insel_right_q, insel_misc_q);
			if (can_run && active_q && capture && chan != 2'h3)
			begin
				if (state_last)
				begin
					sample_valid_flag_o <= 1'b1;
					case (chan)
						2'h0: left_data_o <= conv_data_i;
						2'h1: right_data_o <= conv_data_i;
						default: misc_data_q <= conv_data_i;
					endcase
				end
			end
			// Run pulse on the first cycle of each capture state that serves a channel
			if (run_next && active_q && state_last && nxt_capture && nxt_chan != 2'h3)
				conv_run_o <= 1'b1;
		end
	end

	// ==========================================
	// Interrupts: capture events set, write one clears, set wins
	always @*
	begin
		irq_set = 3'h0;
		if (can_run && active_q && capture && state_last && chan != 2'h3)
			irq_set[chan] = 1'b1;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			irq_stat_q <= 3'h0;
		else if (wr_en && adr_i == `ASS_OFF_IRQ_STAT && sel_i[0])
			irq_stat_q <= (irq_stat_q & ~dat_i[2:0]) | irq_set;
		else
			irq_stat_q <= irq_stat_q | irq_set;
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule

// >>> ass_conv_model.sv
`timescale 1ns/100ps
// ==========================================
// Converter core: answers each run with a result tagged by channel
module ass_conv_model
(
	input wire clk_i,
	input wire rst_i,
	input wire conv_run_i,
	input wire [1:0] conv_chan_i,
	output reg [14:0] conv_data_o
);
	reg started_q;
	// Result holds until the next run; before the first run the lines toggle so a stale latch shows
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			started_q <= 1'b0;
			conv_data_o <= 15'h2a5a;
		end
		else if (conv_run_i)
		begin
			started_q <= 1'b1;
			conv_data_o <= {conv_chan_i, 13'h01a5};
		end
		else if (!started_q)
			conv_data_o <= ~conv_data_o;
	end
endmodule

// >>> ass_sequencer_props.sv
`timescale 1ns/100ps
// ==========================================
// Port-level checks of the sequencer
module ass_sequencer_props
(
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire conv_run_o,
	input wire [1:0] conv_chan_o,
	input wire conv_set_o,
	input wire converter_powerdown_o,
	input wire sample_valid_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Pulses and state ordering
	chk_run_one_pulse: assert property (conv_run_o |=> !conv_run_o)
		else $error("run longer than one cycle");
	chk_valid_self_clear: assert property (sample_valid_flag_o |=> !sample_valid_flag_o)
		else $error("valid flag did not clear");
	chk_run_after_set: assert property ($rose(conv_run_o) |-> $past(conv_set_o))
		else $error("capture not preceded by set");
	chk_run_not_set: assert property (conv_run_o |-> !conv_set_o)
		else $error("run during set state");
	chk_run_has_chan: assert property (conv_run_o |-> conv_chan_o != 2'd3)
		else $error("run without a channel");
	// Power-down keeps the sequencer quiet; short grace for a capture in flight
	chk_pd_no_run: assert property (converter_powerdown_o |-> !conv_run_o)
		else $error("run while powered down");
	chk_pd_no_valid: assert property (converter_powerdown_o && $past(converter_powerdown_o, 3) |-> !sample_valid_flag_o)
		else $error("valid while powered down");
	// Bus answer after one wait
	chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack not given");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	cover property (conv_run_o && conv_chan_o == 2'd2);
	cover property (sample_valid_flag_o);
	cover property ($fell(converter_powerdown_o));
	cover property (conv_set_o ##1 conv_run_o);
endmodule
bind ass_sequencer ass_sequencer_props u_props(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .conv_run_o(conv_run_o), .conv_chan_o(conv_chan_o), .conv_set_o(conv_set_o),
	.converter_powerdown_o(converter_powerdown_o), .sample_valid_flag_o(sample_valid_flag_o));

// >>> ass_sequencer_tb.sv
`timescale 1ns/100ps
`include "ass_defs.vh"
// ==========================================
// Bench for the auto-mode sequencer
module ass_sequencer_tb;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg cyc_i = 1'b0;
	reg stb_i = 1'b0;
	reg we_i = 1'b0;
	reg [7:0] adr_i = 8'h00;
	reg [3:0] sel_i = 4'h1;
	reg [31:0] dat_i = 32'h0;
	wire [31:0] dat_o;
	wire ack_o, irq_o, conv_run_o, conv_set_o, converter_powerdown_o, sample_valid_flag_o;
	wire [14:0] conv_data_i, left_data_o, right_data_o;
	wire [1:0] conv_chan_o;
	wire [7:0] conv_insel_o;
	integer n_mismatch = 0;
	integer checked = 0;
	integer i, k, t0, nv;
	reg found;
	reg [31:0] rd;
	// Rows: max index, enables, runs per period, first channel, period in cycles
	reg [23:0] rows [0:5];
	reg [7:0] insel [0:2];
	always #5 clk_i = ~clk_i;
	ass_sequencer u_dut(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .conv_data_i(conv_data_i),
		.conv_run_o(conv_run_o), .conv_chan_o(conv_chan_o), .conv_insel_o(conv_insel_o), .conv_set_o(conv_set_o),
		.converter_powerdown_o(converter_powerdown_o), .sample_valid_flag_o(sample_valid_flag_o),
		.left_data_o(left_data_o), .right_data_o(right_data_o));
	ass_conv_model u_conv(.clk_i(clk_i), .rst_i(rst_i), .conv_run_i(conv_run_o), .conv_chan_i(conv_chan_o),
		.conv_data_o(conv_data_i));
	// Value compare
	task cmp(input [31:0] got, input [31:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task results;
	begin
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	// One classic cycle; waits for ack under a bound
	task wb(input w, input [7:0] a, input [7:0] d);
		integer j;
	begin
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		for (j = 0; j < 50 && ack_o !== 1'b1; j = j + 1)
			@(posedge clk_i);
		if (j == 50)
		begin
			n_mismatch = n_mismatch + 1;
			results;
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	end
	endtask
	// Waits for the next run pulse, counting valid pulses meanwhile; absence is not a hang here
	task wait_run;
		integer j;
	begin
		found = 1'b0;
		for (j = 0; j < 200 && !found; j = j + 1)
		begin
			@(posedge clk_i);
			#1;
			if (sample_valid_flag_o === 1'b1)
				nv = nv + 1;
			if (conv_run_o === 1'b1)
				found = 1'b1;
		end
	end
	endtask
	initial
	begin
		rows[0] = 24'h67301a;
		rows[1] = 24'h452012;
		rows[2] = 24'h432010;
		rows[3] = 24'h211008;
		rows[4] = 24'h24120a;
		rows[5] = 24'h220300;
		insel[0] = 8'h12;
		insel[1] = 8'h34;
		insel[2] = 8'haf;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		cmp(converter_powerdown_o, 1);
		wb(0, `ASS_OFF_POWER, 8'h00);
		cmp(rd, 32'h20);
		wb(1, `ASS_OFF_LEN_HI, 8'h03);
		wb(1, `ASS_OFF_LR_CAP_LO, 8'h05);
		wb(1, `ASS_OFF_MISC_CAP_LO, 8'h07);
		wb(1, `ASS_OFF_INSEL_LEFT, insel[0]);
		wb(1, `ASS_OFF_INSEL_RIGHT, insel[1]);
		wb(1, `ASS_OFF_INSEL_MISC, insel[2]);
		// Channel mixes: period is the sum of enabled set and capture lengths
		for (i = 0; i < 6; i = i + 1)
		begin
			wb(1, `ASS_OFF_POWER, 8'h20);
			wb(1, `ASS_OFF_CHAN_CTRL, rows[i][23:16]);
			wb(1, `ASS_OFF_POWER, 8'h00);
			wait_run;
			t0 = $time;
			nv = 0;
			cmp(found, rows[i][15:12] != 4'h0);
			if (found)
			begin
				cmp(conv_chan_o, rows[i][11:8]);
				cmp(conv_set_o, 0);
				for (k = 0; k < rows[i][15:12]; k = k + 1)
				begin
					cmp(conv_insel_o, insel[conv_chan_o]);
					wait_run;
				end
				cmp(($time - t0) / 10, rows[i][7:0]);
				cmp(nv, rows[i][15:12]);
			end
			$display("row %0d done", i);
		end
		// Latched results
		cmp(left_data_o, 15'h01a5);
		cmp(right_data_o, 15'h21a5);
		wb(0, `ASS_OFF_MISC_DAT_LO, 8'h00);
		cmp(rd, 32'ha5);
		wb(0, `ASS_OFF_MISC_DAT_HI, 8'h00);
		cmp(rd & 32'h7f, 32'h41);
		$display("data test done");
		// Interrupt: sticky status, mask, write one to clear
		wb(0, `ASS_OFF_IRQ_STAT, 8'h00);
		cmp(rd, 32'h07);
		cmp(irq_o, 0);
		wb(1, `ASS_OFF_IRQ_MASK, 8'h05);
		#1;
		cmp(irq_o, 1);
		wb(1, `ASS_OFF_IRQ_STAT, 8'h05);
		#1;
		cmp(irq_o, 0);
		wb(0, `ASS_OFF_IRQ_STAT, 8'h00);
		cmp(rd, 32'h02);
		wb(0, 8'hfc, 8'h00);
		cmp(rd, 32'h0);
		$display("interrupt test done");
		// Second reset in mid-run
		wb(1, `ASS_OFF_CHAN_CTRL, 8'h67);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		cmp(converter_powerdown_o, 1);
		cmp(conv_run_o, 0);
		cmp(left_data_o, 0);
		wb(0, `ASS_OFF_CHAN_CTRL, 8'h00);
		cmp(rd, 32'h0);
		wait_run;
		cmp(found, 0);
		$display("reset test done");
		results;
	end
endmodule
